// ==== core_timing_defs.vh ====
// Constants for the instruction timing sequencer and its opcode decoder.
// Assumes the includer holds one clock domain and 8-bit opcodes.
//
// Summary of operation
// - All execution is counted in system clocks, never in machine cycles.
// - By default an instruction takes as many clocks as code bytes.
// - A conditional branch not taken finishes one clock sooner than taken.
// - External-data moves reach only on-chip extended RAM or program flash.
// - Accumulator operation with bank register source: one byte, one clock.
// - Accumulator operation with indirect RAM source: one byte, two clocks.
// - Accumulator operation with direct or immediate source: two bytes, two.
// - AND, OR, XOR of immediate into direct byte: three bytes, three.
// - Increment or decrement of direct or indirect byte takes two clocks.
// - Clear, complement, rotates and swap of accumulator: one byte, one.
// - Code byte reads off data pointer or PC: one byte, three clocks.
// - All six external-data moves are one byte and three clocks.
// - Loading the data pointer with a constant: three bytes, three clocks.
// - Direct to direct, or immediate to direct, move: three bytes, three.
// - Accumulator to indirect RAM one byte; direct or immediate two; both two.
// - Indirect RAM to direct byte move: two bytes, two clocks.
// - Stack push and pop of a direct byte: two bytes, two clocks.
// - Low nibble exchange swaps bits 3 to 0 only; one byte, two clocks.
// - Direct byte into bank register: two bytes, two clocks.
// - Opcodes and addressing follow the standard 8051 set; only timing differs.
// - Relative target is next instruction address plus signed 8-bit offset.
// - The undefined opcode behaves exactly like the no-operation opcode.
// - Bank register operand selects one of eight in the active bank.

`ifndef CORE_TIMING_DEFS_VH
`define CORE_TIMING_DEFS_VH

// Instruction lengths in code bytes
`define LEN1 2'h1
`define LEN2 2'h2
`define LEN3 2'h3

// Execution times in system clocks
`define CYC1 4'h1
`define CYC2 4'h2
`define CYC3 4'h3
`define CYC4 4'h4
`define CYC5 4'h5
`define CYC8 4'h8

// Remaining-cycle counter values
`define CNT_ZERO 4'h0
`define CNT_ONE  4'h1

// Opcode field positions
`define OPC_BANK_FLAG 3
`define OPC_IX_BIT    0
`define OPC_EXT_WR    4
`define REL_SIGN      7

// Undefined opcode that runs as a no-operation
`define OPC_UNDEF 8'ha5

`endif

// ==== opcode_timing_decode.v ====
// Opcode decoder: code bytes, clocks and external-move class per opcode.
// Assumes a purely combinational use by the sequencer on the same clock.
`timescale 1ns/100ps

`include "core_timing_defs.vh"

module opcode_timing_decode
(
   // Opcode in
   input  wire [7:0] opcode,
   // Decoded timing
   output reg  [1:0] len,
   output reg  [3:0] cyc,
   output reg        is_cond,
   // External data move class
   output reg        is_ext,
   output reg        ext_wr,
   output reg        ext_dp16
);

   always @*
   begin
      len      = `LEN1;
      cyc      = `CYC1;
      is_cond  = 1'b0;
      is_ext   = 1'b0;
      ext_wr   = opcode[`OPC_EXT_WR];
      ext_dp16 = 1'b0;
      if (opcode[`OPC_BANK_FLAG])
      begin
         case (opcode[7:4])
            4'h7, 4'h8, 4'ha :
            begin
               len = `LEN2;
               cyc = `CYC2;
            end
            4'hb :
            begin
               len     = `LEN3;
               cyc     = `CYC3;
               is_cond = 1'b1;
            end
            4'hd :
            begin
               len     = `LEN2;
               cyc     = `CYC2;
               is_cond = 1'b1;
            end
            default : ;
         endcase
      end
      else if (opcode[3:1] == 3'h3)
      begin
         cyc = `CYC2;
         case (opcode[7:4])
            4'h7, 4'h8, 4'ha : len = `LEN2;
            4'hb :
            begin
               len     = `LEN3;
               cyc     = `CYC4;
               is_cond = 1'b1;
            end
            default : ;
         endcase
      end
      else
      begin
         case (opcode[3:0])
            4'h5 :
            begin
               len = `LEN2;
               cyc = `CYC2;
               case (opcode[7:4])
                  4'h7, 4'h8 :
                  begin
                     len = `LEN3;
                     cyc = `CYC3;
                  end
                  4'ha :
                  begin
                     len = `LEN1;
                     cyc = `CYC1;
                  end
                  4'hb, 4'hd :
                  begin
                     len     = `LEN3;
                     cyc     = `CYC3;
                     is_cond = 1'b1;
                  end
                  default : ;
               endcase
            end
            4'h4 :
            begin
               case (opcode[7:4])
                  4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9 :
                  begin
                     len = `LEN2;
                     cyc = `CYC2;
                  end
                  4'h8 : cyc = `CYC8;
                  4'ha : cyc = `CYC4;
                  4'hb :
                  begin
                     len     = `LEN3;
                     cyc     = `CYC3;
                     is_cond = 1'b1;
                  end
                  default : ;
               endcase
            end
            4'h3 :
            begin
               case (opcode[7:4])
                  4'h4, 4'h5, 4'h6 :
                  begin
                     len = `LEN3;
                     cyc = `CYC3;
                  end
                  4'h7, 4'h8, 4'h9 : cyc = `CYC3;
                  4'he, 4'hf :
                  begin
                     cyc    = `CYC3;
                     is_ext = 1'b1;
                  end
                  default : ;
               endcase
            end
            4'h2 :
            begin
               len = `LEN2;
               cyc = `CYC2;
               case (opcode[7:4])
                  4'h0, 4'h1 :
                  begin
                     len = `LEN3;
                     cyc = `CYC4;
                  end
                  4'h2, 4'h3 :
                  begin
                     len = `LEN1;
                     cyc = `CYC5;
                  end
                  4'he, 4'hf :
                  begin
                     len    = `LEN1;
                     cyc    = `CYC3;
                     is_ext = 1'b1;
                  end
                  default : ;
               endcase
            end
            4'h1 :
            begin
               len = `LEN2;
               cyc = `CYC3;
            end
            default :
            begin
               case (opcode[7:4])
                  4'h1, 4'h2, 4'h3 :
                  begin
                     len     = `LEN3;
                     cyc     = `CYC3;
                     is_cond = 1'b1;
                  end
                  4'h4, 4'h5, 4'h6, 4'h7 :
                  begin
                     len     = `LEN2;
                     cyc     = `CYC2;
                     is_cond = 1'b1;
                  end
                  4'h8 :
                  begin
                     len = `LEN2;
                     cyc = `CYC3;
                  end
                  4'h9 :
                  begin
                     len = `LEN3;
                     cyc = `CYC3;
                  end
                  4'ha, 4'hb, 4'hc, 4'hd :
                  begin
                     len = `LEN2;
                     cyc = `CYC2;
                  end
                  4'he, 4'hf :
                  begin
                     cyc      = `CYC3;
                     is_ext   = 1'b1;
                     ext_dp16 = 1'b1;
                  end
                  default : ;
               endcase
            end
         endcase
      end
   end

endmodule

// ==== cycle_exact_core_timing.v ====
// Instruction timing sequencer for a pipelined 8-bit core.
// Assumes all inputs come from core logic on ref_clk; opcode, pc, offset,
// condition and operand values are valid together with op_valid.
`timescale 1ns/100ps

`include "core_timing_defs.vh"

module cycle_exact_core_timing
(
   // Clock and reset
   input  wire        ref_clk,
   input  wire        arst_n,
   // Instruction issue
   input  wire        op_valid,
   input  wire [7:0]  opcode,
   input  wire [15:0] op_pc,
   input  wire [7:0]  rel_offset,
   input  wire        cond_true,
   output wire        op_ready,
   // Core context
   input  wire [1:0]  reg_bank,
   input  wire        flash_sel,
   input  wire [7:0]  eram_page,
   input  wire [15:0] data_pointer16,
   input  wire [7:0]  ix_value,
   input  wire [7:0]  acc_value,
   input  wire [7:0]  ind_ram_value,
   // Execution status
   output wire        busy,
   output reg         instr_done_q,
   output reg  [7:0]  cur_opcode_q,
   output reg  [1:0]  cur_len_q,
   output reg  [3:0]  cur_cycles_q,
   output reg         cur_taken_q,
   // Program flow
   output reg  [15:0] next_pc_q,
   output reg  [15:0] branch_target_q,
   // Register bank addressing
   output reg  [7:0]  bank_reg_addr_q,
   // External data move
   output reg         ext_req_q,
   output reg         ext_wr_q,
   output reg  [15:0] ext_addr_q,
   output reg         ext_to_flash_q,
   output reg         ext_to_eram_q,
   // Low nibble exchange results
   output reg  [7:0]  nibx_acc_q,
   output reg  [7:0]  nibx_ram_q,
   // Activity counters
   output reg  [15:0] retired_count_q,
   output reg  [15:0] cycle_count_q
);

   ////////////////////////////////////////////////////////////////////////
   // States and functions

   localparam ST_IDLE = 1'b0;
   localparam ST_EXEC = 1'b1;

   // Internal RAM address of register idx in the selected bank
   function [7:0] bank_addr;
      input [1:0] bank;
      input [2:0] idx;
      begin
         bank_addr = {3'h0, bank, idx};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   wire [1:0]  dec_len;
   wire [3:0]  dec_cyc;
   wire        dec_cond;
   wire        dec_ext;
   wire        dec_ext_wr;
   wire        dec_ext_dp16;
   wire        fire;
   wire        taken;
   wire [3:0]  cyc_eff;
   wire [15:0] pc_after;
   wire [15:0] rel_sext;
   wire        is_bank_op;
   wire        is_ind_op;

   reg         state_q;
   reg         state_d;
   reg  [3:0]  cnt_q;
   reg  [3:0]  cnt_d;
   reg         done_d;
   reg  [7:0]  bank_addr_d;

   ////////////////////////////////////////////////////////////////////////
   // Opcode decode

   opcode_timing_decode u_decode
   (
      .opcode   (opcode),
      .len      (dec_len),
      .cyc      (dec_cyc),
      .is_cond  (dec_cond),
      .is_ext   (dec_ext),
      .ext_wr   (dec_ext_wr),
      .ext_dp16 (dec_ext_dp16)
   );

   ////////////////////////////////////////////////////////////////////////
   // Issue and cycle accounting

   // One instruction at a time; a new one is taken once the count is spent
   assign op_ready = (state_q == ST_IDLE);
   assign fire     = op_valid & op_ready;
   assign busy     = (state_q == ST_EXEC);

   // Taken branch costs one clock more than the not-taken path
   assign taken   = dec_cond & cond_true;
   assign cyc_eff = dec_cyc + {3'h0, taken};

   always @*
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      done_d  = 1'b0;
      case (state_q)
         ST_IDLE :
         begin
            if (fire)
            begin
               // Counter holds the clocks left after the issue clock
               cnt_d = cyc_eff - `CNT_ONE;
               if (cyc_eff == `CNT_ONE)
               begin
                  done_d = 1'b1;
               end
               else
               begin
                  state_d = ST_EXEC;
               end
            end
         end
         ST_EXEC :
         begin
            cnt_d = cnt_q - `CNT_ONE;
            if (cnt_q == `CNT_ONE)
            begin
               state_d = ST_IDLE;
               done_d  = 1'b1;
            end
         end
         default :
         begin
            state_d = ST_IDLE;
            cnt_d   = `CNT_ZERO;
         end
      endcase
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q      <= ST_IDLE;
         cnt_q        <= `CNT_ZERO;
         instr_done_q <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         instr_done_q <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Current instruction record

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cur_opcode_q <= 8'h00;
         cur_len_q    <= 2'h0;
         cur_cycles_q <= 4'h0;
         cur_taken_q  <= 1'b0;
      end
      else if (fire)
      begin
         // The undefined opcode is recorded as its no-operation timing
         cur_opcode_q <= opcode;
         cur_len_q    <= dec_len;
         cur_cycles_q <= cyc_eff;
         cur_taken_q  <= taken;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program flow

   assign pc_after = op_pc + {14'h0000, dec_len};
   assign rel_sext = {{8{rel_offset[`REL_SIGN]}}, rel_offset};

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         next_pc_q       <= 16'h0000;
         branch_target_q <= 16'h0000;
      end
      else if (fire)
      begin
         next_pc_q       <= pc_after;
         // Offset counts from the first byte of the following instruction
         branch_target_q <= pc_after + rel_sext;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register bank addressing

   assign is_bank_op = opcode[`OPC_BANK_FLAG];
   assign is_ind_op  = (opcode[3:1] == 3'h3) |
                       (dec_ext & ~dec_ext_dp16);

   always @*
   begin
      bank_addr_d = bank_reg_addr_q;
      if (is_bank_op)
      begin
         bank_addr_d = bank_addr(reg_bank, opcode[2:0]);
      end
      else if (is_ind_op)
      begin
         // Index register is R0 or R1 of the active bank
         bank_addr_d = bank_addr(reg_bank,
                                 {2'h0, opcode[`OPC_IX_BIT]});
      end
   end

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bank_reg_addr_q <= 8'h00;
      end
      else if (fire)
      begin
         bank_reg_addr_q <= bank_addr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External data move routing

   // Only on-chip targets exist: flash when selected, otherwise extended RAM
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ext_req_q      <= 1'b0;
         ext_wr_q       <= 1'b0;
         ext_addr_q     <= 16'h0000;
         ext_to_flash_q <= 1'b0;
         ext_to_eram_q  <= 1'b0;
      end
      else
      begin
         ext_req_q      <= fire & dec_ext;
         ext_to_flash_q <= fire & dec_ext & flash_sel;
         ext_to_eram_q  <= fire & dec_ext & ~flash_sel;
         if (fire & dec_ext)
         begin
            ext_wr_q <= dec_ext_wr;
            if (dec_ext_dp16)
            begin
               ext_addr_q <= data_pointer16;
            end
            else
            begin
               ext_addr_q <= {eram_page, ix_value};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Low nibble exchange

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         nibx_acc_q <= 8'h00;
         nibx_ram_q <= 8'h00;
      end
      else if (fire & (opcode[7:1] == 7'h6b))
      begin
         // Upper nibbles stay with their owners
         nibx_acc_q <= {acc_value[7:4], ind_ram_value[3:0]};
         nibx_ram_q <= {ind_ram_value[7:4], acc_value[3:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Activity counters

   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         retired_count_q <= 16'h0000;
         cycle_count_q   <= 16'h0000;
      end
      else
      begin
         if (done_d)
         begin
            retired_count_q <= retired_count_q + 16'h0001;
         end
         if (fire | busy)
         begin
            cycle_count_q <= cycle_count_q + 16'h0001;
         end
      end
   end

endmodule

// ==== core_timing_properties.sv ====
// Concurrent checks on the instruction timing sequencer ports.
// Assumes one clock domain, ref_clk, with asynchronous arst_n.
`timescale 1ns/100ps
module core_timing_checker
(
   // Clock and issue
   input logic        ref_clk,
   input logic        arst_n,
   input logic        op_valid,
   input logic [7:0]  opcode,
   input logic [15:0] op_pc,
   input logic [7:0]  rel_offset,
   input logic        cond_true,
   input logic        op_ready,
   // Context
   input logic [1:0]  reg_bank,
   input logic        flash_sel,
   input logic [15:0] data_pointer16,
   input logic [7:0]  acc_value,
   input logic [7:0]  ind_ram_value,
   // Status
   input logic        busy,
   input logic        instr_done_q,
   input logic [7:0]  cur_opcode_q,
   input logic [1:0]  cur_len_q,
   input logic [3:0]  cur_cycles_q,
   input logic [15:0] next_pc_q,
   input logic [15:0] branch_target_q,
   input logic [7:0]  bank_reg_addr_q,
   input logic        ext_req_q,
   input logic        ext_wr_q,
   input logic [15:0] ext_addr_q,
   input logic        ext_to_flash_q,
   input logic        ext_to_eram_q,
   input logic [7:0]  nibx_acc_q,
   input logic [15:0] retired_count_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   wire        iss = op_valid && op_ready;
   wire [2:0]  reg_sel = opcode[2:0];
   wire [7:0]  nibx_exp = {acc_value[7:4], ind_ram_value[3:0]};
   wire [15:0] rel16 = {{8{rel_offset[7]}}, rel_offset};
   ////////////////////////////////////////////////////////////////////////
   ready_idle_a: assert property (instr_done_q |-> op_ready)
      else $error("done while busy");
   held_refused_a: assert property (busy && op_valid |=>
      $stable(cur_opcode_q) && $stable(next_pc_q)) else $error("refused");
   mul_count_a: assert property (iss && opcode == 8'ha4 |=>
      busy [*3] ##1 instr_done_q) else $error("multiply clocks");
   div_count_a: assert property (iss && opcode == 8'h84 |=>
      busy [*7] ##1 instr_done_q) else $error("divide clocks");
   branch_taken_a: assert property (iss && opcode == 8'h40 &&
      cond_true |=> busy [*2] ##1 instr_done_q) else $error("taken branch");
   branch_short_a: assert property (iss && opcode == 8'h40 &&
      !cond_true |=> busy ##1 instr_done_q && !busy)
      else $error("branch not taken");
   undef_nop_a: assert property (iss && opcode == 8'ha5 |=>
      instr_done_q && cur_len_q == 2'h1 && cur_cycles_q == 4'h1)
      else $error("undefined opcode");
   ext_route_a: assert property (ext_req_q || ext_to_flash_q ||
      ext_to_eram_q |-> ext_req_q && (ext_to_flash_q ^ ext_to_eram_q))
      else $error("ext target");
   ext_read_a: assert property (iss && opcode == 8'he0 |=>
      ext_req_q && !ext_wr_q && ext_addr_q == $past(data_pointer16) &&
      ext_to_flash_q == $past(flash_sel)) else $error("ext read");
   pc_target_a: assert property (iss |=>
      next_pc_q == $past(op_pc) + 16'(cur_len_q) &&
      branch_target_q == next_pc_q + $past(rel16)) else $error("targets");
   bank_addr_a: assert property (iss && opcode[3] |=>
      bank_reg_addr_q == {3'h0, $past(reg_bank), $past(reg_sel)})
      else $error("bank address");
   nibble_swap_a: assert property (iss && opcode == 8'hd6 |=>
      nibx_acc_q == $past(nibx_exp)) else $error("nibble exchange");
   retire_step_a: assert property (instr_done_q |->
      retired_count_q == $past(retired_count_q) + 16'h1)
      else $error("retired count");
   c_mul: cover property (iss && opcode == 8'ha4);
   c_taken: cover property (iss && opcode == 8'h40 && cond_true);
   c_ext: cover property (ext_req_q && ext_to_flash_q);
   c_held: cover property (busy && op_valid);
endmodule
bind cycle_exact_core_timing core_timing_checker chk (.ref_clk, .arst_n,
   .op_valid, .opcode, .op_pc, .rel_offset, .cond_true, .op_ready,
   .reg_bank, .flash_sel, .data_pointer16, .acc_value, .ind_ram_value,
   .busy, .instr_done_q, .cur_opcode_q, .cur_len_q, .cur_cycles_q,
   .next_pc_q, .branch_target_q, .bank_reg_addr_q, .ext_req_q, .ext_wr_q,
   .ext_addr_q, .ext_to_flash_q, .ext_to_eram_q, .nibx_acc_q,
   .retired_count_q);

// ==== onchip_mem_model.sv ====
// Model of the indirect data RAM and the two on-chip move targets.
// Assumes external requests are one-cycle pulses on ref_clk.
`timescale 1ns/100ps
module onchip_mem_model
(
   // Clock
   input  wire        ref_clk,
   // Indirect RAM read
   input  wire [7:0]  ix_value,
   output wire [7:0]  ind_ram_value,
   // External move routing
   input  wire        ext_req_q,
   input  wire        ext_to_flash_q,
   input  wire        ext_to_eram_q,
   output reg  [15:0] flash_hits,
   output reg  [15:0] eram_hits
);
   assign ind_ram_value = ix_value ^ 8'h5a;
   initial flash_hits = 16'h0;
   initial eram_hits = 16'h0;
   // Only flash and extended RAM exist; there is no off-chip port
   always @(posedge ref_clk)
      if (ext_req_q)
      begin
         flash_hits <= flash_hits + {15'h0, ext_to_flash_q};
         eram_hits  <= eram_hits + {15'h0, ext_to_eram_q};
      end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the instruction timing sequencer.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/100ps
module testbench;
   localparam [319:0] OPS = {8'h28, 8'h2f, 8'he4, 8'hf4, 8'h23, 8'h33,
      8'h03, 8'h13, 8'hc4, 8'ha3, 8'hd3, 8'hc3, 8'h00, 8'ha5, 8'h26, 8'h06,
      8'hf6, 8'hd6, 8'h25, 8'h24, 8'h05, 8'ha6, 8'h76, 8'h86, 8'hc0, 8'hd0,
      8'ha8, 8'h53, 8'h90, 8'h85, 8'h75, 8'h40, 8'ha4, 8'h84, 8'h93, 8'h83,
      8'he0, 8'he2, 8'hf0, 8'hf2};
   reg         ref_clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         op_valid = 1'b0;
   reg  [7:0]  opcode = 8'h00;
   reg  [15:0] op_pc = 16'h0;
   reg  [7:0]  rel_offset = 8'h00;
   reg         cond_true = 1'b0;
   reg  [1:0]  reg_bank = 2'h0;
   reg         flash_sel = 1'b0;
   reg  [7:0]  eram_page = 8'h00;
   reg  [15:0] data_pointer16 = 16'h0;
   reg  [7:0]  ix_value = 8'h00;
   reg  [7:0]  acc_value = 8'h00;
   wire [7:0]  ind_ram_value, cur_opcode_q, bank_reg_addr_q;
   wire [7:0]  nibx_acc_q, nibx_ram_q;
   wire [1:0]  cur_len_q;
   wire [3:0]  cur_cycles_q;
   wire [15:0] next_pc_q, branch_target_q, ext_addr_q, retired_count_q;
   wire [15:0] cycle_count_q, flash_hits, eram_hits;
   wire        op_ready, busy, instr_done_q, cur_taken_q, ext_req_q;
   wire        ext_wr_q, ext_to_flash_q, ext_to_eram_q;
   integer     num_errors = 0;
   integer     checks = 0;
   integer     seed = 32'h76da;
   integer     retired = 0;
   integer     cyc_sum = 0;
   integer     nfl = 0;
   integer     nxr = 0;
   integer     i;
   always #2 ref_clk = ~ref_clk;
   cycle_exact_core_timing DUT (.ref_clk, .arst_n, .op_valid, .opcode,
      .op_pc, .rel_offset, .cond_true, .op_ready, .reg_bank, .flash_sel,
      .eram_page, .data_pointer16, .ix_value, .acc_value, .ind_ram_value,
      .busy, .instr_done_q, .cur_opcode_q, .cur_len_q, .cur_cycles_q,
      .cur_taken_q, .next_pc_q, .branch_target_q, .bank_reg_addr_q,
      .ext_req_q, .ext_wr_q, .ext_addr_q, .ext_to_flash_q, .ext_to_eram_q,
      .nibx_acc_q, .nibx_ram_q, .retired_count_q, .cycle_count_q);
   onchip_mem_model mem (.ref_clk, .ix_value, .ind_ram_value, .ext_req_q,
      .ext_to_flash_q, .ext_to_eram_q, .flash_hits, .eram_hits);
   ////////////////////////////////////////////////////////////////////////
   // Expected {bytes, clocks} per opcode
   function [5:0] lc(input [7:0] op, input c);
      case (op)
         8'h28, 8'h2f, 8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
         8'ha3, 8'hd3, 8'hc3, 8'h00, 8'ha5: lc = 6'h11;
         8'h26, 8'h06, 8'hf6, 8'hd6: lc = 6'h12;
         8'h25, 8'h24, 8'h05, 8'ha6, 8'h76, 8'h86, 8'hc0, 8'hd0, 8'ha8:
            lc = 6'h22;
         8'h53, 8'h90, 8'h85, 8'h75: lc = 6'h33;
         8'h40: lc = c ? 6'h23 : 6'h22;
         8'ha4: lc = 6'h14;
         8'h84: lc = 6'h18;
         default: lc = 6'h13;
      endcase
   endfunction
   task check(input [63:0] nm, input [15:0] ex, input [15:0] got);
      begin
         checks = checks + 1;
         if (got !== ex)
         begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", checks, num_errors);
         if (num_errors == 0 && checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // Second pass re-issues the same instruction, held high while busy
   task issue(input [7:0] op, input c, input two);
      integer     k;
      integer     r;
      reg [5:0]   e;
      reg         isx;
      reg [7:0]   ind;
      begin
         e = lc(op, c);
         isx = op[7:5] == 3'h7 && op[3:2] == 2'h0 && !op[0];
         opcode = op;
         cond_true = c;
         op_pc = $random(seed);
         rel_offset = $random(seed);
         reg_bank = $random(seed);
         flash_sel = $random(seed);
         eram_page = $random(seed);
         data_pointer16 = $random(seed);
         ix_value = $random(seed);
         acc_value = $random(seed);
         ind = ix_value ^ 8'h5a;
         op_valid = 1'b1;
         for (r = 0; r <= two; r = r + 1)
         begin
            @(posedge ref_clk);
            #1;
            op_valid = r < two;
            check("len", e[5:4], cur_len_q);
            check("next_pc", op_pc + e[5:4], next_pc_q);
            check("target", op_pc + e[5:4] + {{8{rel_offset[7]}}, rel_offset},
               branch_target_q);
            if (op[3] || op[3:1] == 3'h3 || op == 8'he2 || op == 8'hf2)
               check("bank", {3'h0, reg_bank, op[3] ? op[2:0] : {2'h0, op[0]}},
                  bank_reg_addr_q);
            check("ext_req", isx, ext_req_q);
            if (isx)
            begin
               check("ext_wr", op[4], ext_wr_q);
               check("ext_addr", op[1] ? {eram_page, ix_value} : data_pointer16,
                  ext_addr_q);
               check("to_flash", flash_sel, ext_to_flash_q);
               check("to_eram", !flash_sel, ext_to_eram_q);
               nfl = nfl + flash_sel;
               nxr = nxr + !flash_sel;
            end
            if (op == 8'hd6)
            begin
               check("nibx_acc", {acc_value[7:4], ind[3:0]}, nibx_acc_q);
               check("nibx_ram", {ind[7:4], acc_value[3:0]}, nibx_ram_q);
            end
            k = 1;
            while (instr_done_q !== 1'b1 && k < 12)
            begin
               @(posedge ref_clk);
               #1;
               k = k + 1;
            end
            check("cycles", e[3:0], k);
            check("cur_cyc", e[3:0], cur_cycles_q);
            retired = retired + 1;
            check("retired", retired, retired_count_q);
            check("cur_op", op, cur_opcode_q);
            check("taken", op == 8'h40 && c, cur_taken_q);
            cyc_sum = cyc_sum + e[3:0];
            check("cyc_cnt", cyc_sum, cycle_count_q);
            if (k >= 12)
            begin
               num_errors = num_errors + 1;
               test_done;
            end
         end
      end
   endtask
   initial
   begin
      repeat (4) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      check("ready", 16'h1, op_ready);
      for (i = 0; i < 40; i = i + 1)
         issue(OPS[8*i +: 8], 1'b0, 1'b0);
      issue(8'h40, 1'b1, 1'b1);
      issue(8'ha4, 1'b0, 1'b1);
      issue(8'h84, 1'b0, 1'b1);
      issue(8'h00, 1'b0, 1'b1);
      $display("test table done");
      for (i = 0; i < 300; i = i + 1)
         issue(OPS[8*({$random(seed)} % 40) +: 8], $random(seed), 1'b0);
      $display("test random done");
      check("flash_n", nfl, flash_hits);
      check("eram_n", nxr, eram_hits);
      arst_n = 1'b0;
      #1;
      check("rst_cnt", 16'h0, retired_count_q);
      check("rst_rdy", 16'h1, op_ready);
      @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      retired = 0;
      cyc_sum = 0;
      issue(8'h26, 1'b0, 1'b0);
      $display("test reset done");
      test_done;
   end
endmodule
